// File: cocr_cfg.svh
// Register offsets, field positions, reset values and interrupt bit positions for the camera output config
`ifndef COCR_CFG_SVH
`define COCR_CFG_SVH

`define COCR_ADDR_W 8
`define COCR_DATA_W 8

// Register offsets
`define COCR_OFF_RAW_PLACE 8'h09
`define COCR_OFF_PORT_A_EN 8'h13
`define COCR_OFF_PORT_B_EN 8'h14
`define COCR_OFF_PASS_ROUTE 8'h16
`define COCR_OFF_VC_SELECT 8'h2E
`define COCR_OFF_IRQ_STATUS 8'h40
`define COCR_OFF_IRQ_ENABLE 8'h41
`define COCR_OFF_IRQ_CLEAR 8'h42

// Reset values
`define COCR_RST_RAW_PLACE 8'h00
`define COCR_RST_PORT_A_EN 8'h3F
`define COCR_RST_PORT_B_EN 8'h00
`define COCR_RST_PASS_ROUTE 8'h02
`define COCR_RST_VC_SELECT 8'h00
`define COCR_RST_IRQ 8'h00

// Field positions
`define COCR_BIT_RAW_MSB 4
`define COCR_BIT_REG_OVERRIDE 7
`define COCR_LANE_EN_HI 5
`define COCR_LANE_EN_LO 0
`define COCR_LANE_ALL_ON 6'h3F
`define COCR_LANE_ALL_OFF 6'h00
`define COCR_BIT_PASS_PIN3 2
`define COCR_BIT_PASS_PIN0 1
`define COCR_BIT_PASS_STATUS 0
`define COCR_VC_HI 7
`define COCR_VC_LO 6

// Interrupt status bit positions
`define COCR_IRQ_PASS_RISE 0
`define COCR_IRQ_PASS_FALL 1

`endif

// File: cocr_pkg.sv
// Types shared by the camera output configuration block
package cocr_pkg;
   typedef logic [7:0] cocr_byte_t;
   typedef logic [1:0] cocr_vc_t;
   typedef logic [5:0] cocr_lanes_t;
endpackage : cocr_pkg

// File: cocr_pin_sync.sv
// Three-stage synchroniser with agreement filter for an outside pin
`timescale 1ns/1ps
module cocr_pin_sync
   import cocr_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic PIN,
   output logic LEVEL
);
   logic s1;
   logic s2;
   logic s3;

   // Change is taken only when stages two and three agree
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         LEVEL <= 1'b0;
      end else begin
         s1 <= PIN;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            LEVEL <= s3;
         end
      end
   end
endmodule : cocr_pin_sync

// File: cocr_raw_place.sv
// Places RAW pixel data on low or high bits of the colour bus
`timescale 1ns/1ps
module cocr_raw_place
   import cocr_pkg::*;
#(
   parameter int RAW_W = 12,
   parameter int BUS_W = 24
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic TO_MSB,
   input wire logic [RAW_W-1:0] RAW_IN,
   output logic [BUS_W-1:0] BUS_OUT
);
   wire [BUS_W-1:0] low_placed = {{(BUS_W-RAW_W){1'b0}}, RAW_IN};
   wire [BUS_W-1:0] high_placed = {RAW_IN, {(BUS_W-RAW_W){1'b0}}};
   wire [BUS_W-1:0] next_bus = TO_MSB ? high_placed : low_placed;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         BUS_OUT <= '0;
      end else begin
         BUS_OUT <= next_bus;
      end
   end
endmodule : cocr_raw_place

// File: cocr_regs.sv
// Camera output configuration register bank with pass routing and interrupt
`timescale 1ns/1ps
`include "cocr_cfg.svh"

module cocr_regs
   import cocr_pkg::*;
#(
   parameter int RAW_W = 12,
   parameter int BUS_W = 24
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic PASS_IN,
   input wire logic PORT_A_AUTO_EN,
   input wire logic PORT_B_AUTO_EN,
   input wire logic [RAW_W-1:0] RAW_IN,
   output logic [BUS_W-1:0] COLOUR_BUS,
   output logic [5:0] PORT_A_LANES,
   output logic [5:0] PORT_B_LANES,
   output logic [1:0] STREAM_CHANNEL_TAG,
   output logic GENERAL_PIN_0_OUT,
   output logic GENERAL_PIN_0_OE,
   output logic GENERAL_PIN_3_OUT,
   output logic GENERAL_PIN_3_OE,
   output logic IRQ
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   cocr_byte_t raw_pixel_placement;
   cocr_byte_t output_port_a_enable;
   cocr_byte_t output_port_b_enable;
   logic [7:1] pass_signal_routing;
   cocr_byte_t virtual_channel_select;
   cocr_byte_t irq_status;
   cocr_byte_t irq_enable;
   logic pass_level;
   logic pass_prev;

   // ----------------------------------------------------------------
   // Pass input synchronisation
   // ----------------------------------------------------------------
   cocr_pin_sync u_pass_sync (
      .CLOCK(CLOCK),
      .RST(RST),
      .PIN(PASS_IN),
      .LEVEL(pass_level)
   );

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Full byte compare; aliases of a register never answer
   function automatic logic is_hit(
      input cocr_byte_t addr,
      input cocr_byte_t offset
   );
      return addr == offset;
   endfunction : is_hit

   wire hit_raw = is_hit(ADDR, `COCR_OFF_RAW_PLACE);
   wire hit_pa = is_hit(ADDR, `COCR_OFF_PORT_A_EN);
   wire hit_pb = is_hit(ADDR, `COCR_OFF_PORT_B_EN);
   wire hit_pass = is_hit(ADDR, `COCR_OFF_PASS_ROUTE);
   wire hit_vc = is_hit(ADDR, `COCR_OFF_VC_SELECT);
   wire hit_ist = is_hit(ADDR, `COCR_OFF_IRQ_STATUS);
   wire hit_ien = is_hit(ADDR, `COCR_OFF_IRQ_ENABLE);
   wire hit_icl = is_hit(ADDR, `COCR_OFF_IRQ_CLEAR);

   // Write enables; a write to an unmapped offset lands nowhere
   wire wr_raw = WR && hit_raw;
   wire wr_pa = WR && hit_pa;
   wire wr_pb = WR && hit_pb;
   wire wr_pass = WR && hit_pass;
   wire wr_vc = WR && hit_vc;
   wire wr_ien = WR && hit_ien;
   wire wr_icl = WR && hit_icl;

   cocr_byte_t pass_read;
   assign pass_read = {pass_signal_routing, pass_level};

   cocr_byte_t read_mux;
   always_comb begin
      if (hit_raw) begin
         read_mux = raw_pixel_placement;
      end else if (hit_pa) begin
         read_mux = output_port_a_enable;
      end else if (hit_pb) begin
         read_mux = output_port_b_enable;
      end else if (hit_pass) begin
         read_mux = pass_read;
      end else if (hit_vc) begin
         read_mux = virtual_channel_select;
      end else if (hit_ist) begin
         read_mux = irq_status;
      end else if (hit_ien) begin
         read_mux = irq_enable;
      end else begin
         // Unmapped and write-only clear read as zero
         read_mux = 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Reserved bits are stored as written; software preserves them
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         raw_pixel_placement <= `COCR_RST_RAW_PLACE;
      end else if (wr_raw) begin
         raw_pixel_placement <= WDATA;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         output_port_a_enable <= `COCR_RST_PORT_A_EN;
      end else if (wr_pa) begin
         output_port_a_enable <= WDATA;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         output_port_b_enable <= `COCR_RST_PORT_B_EN;
      end else if (wr_pb) begin
         output_port_b_enable <= WDATA;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pass_signal_routing <= 7'(`COCR_RST_PASS_ROUTE >> 1);
      end else if (wr_pass) begin
         // Bit 0 is live status and has no storage
         pass_signal_routing <= WDATA[7:1];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         virtual_channel_select <= `COCR_RST_VC_SELECT;
      end else if (wr_vc) begin
         virtual_channel_select <= WDATA;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         irq_enable <= `COCR_RST_IRQ;
      end else if (wr_ien) begin
         irq_enable <= WDATA;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         RDATA <= 8'h00;
      end else begin
         RDATA <= RD ? read_mux : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Port enables
   // ----------------------------------------------------------------
   // Without override the chip's own enable decides, all lanes together
   function automatic cocr_lanes_t lane_select(
      input logic override,
      input cocr_lanes_t field,
      input logic auto_en
   );
      cocr_lanes_t chosen;
      if (override) begin
         chosen = field;
      end else if (auto_en) begin
         chosen = `COCR_LANE_ALL_ON;
      end else begin
         chosen = `COCR_LANE_ALL_OFF;
      end
      return chosen;
   endfunction : lane_select

   wire pa_override = output_port_a_enable[`COCR_BIT_REG_OVERRIDE];
   wire pb_override = output_port_b_enable[`COCR_BIT_REG_OVERRIDE];
   wire [5:0] pa_field = output_port_a_enable[`COCR_LANE_EN_HI:`COCR_LANE_EN_LO];
   wire [5:0] pb_field = output_port_b_enable[`COCR_LANE_EN_HI:`COCR_LANE_EN_LO];
   wire [5:0] next_pa = lane_select(pa_override, pa_field, PORT_A_AUTO_EN);
   wire [5:0] next_pb = lane_select(pb_override, pb_field, PORT_B_AUTO_EN);

   // ----------------------------------------------------------------
   // Pass routing and outputs
   // ----------------------------------------------------------------
   wire route_pin3 = pass_signal_routing[`COCR_BIT_PASS_PIN3];
   wire route_pin0 = pass_signal_routing[`COCR_BIT_PASS_PIN0];

   // Lanes are registered so a port sees one clean change per write
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         PORT_A_LANES <= 6'h00;
         PORT_B_LANES <= 6'h00;
      end else begin
         PORT_A_LANES <= next_pa;
         PORT_B_LANES <= next_pb;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         STREAM_CHANNEL_TAG <= 2'h0;
      end else begin
         STREAM_CHANNEL_TAG <= virtual_channel_select[`COCR_VC_HI:`COCR_VC_LO];
      end
   end

   // An unrouted pin is released: enable low, data low
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         GENERAL_PIN_0_OE <= 1'b0;
         GENERAL_PIN_0_OUT <= 1'b0;
      end else begin
         GENERAL_PIN_0_OE <= route_pin0;
         GENERAL_PIN_0_OUT <= route_pin0 & pass_level;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         GENERAL_PIN_3_OE <= 1'b0;
         GENERAL_PIN_3_OUT <= 1'b0;
      end else begin
         GENERAL_PIN_3_OE <= route_pin3;
         GENERAL_PIN_3_OUT <= route_pin3 & pass_level;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   wire pass_rise = pass_level & ~pass_prev;
   wire pass_fall = ~pass_level & pass_prev;
   cocr_byte_t irq_events;
   wire [7:0] rise_event = {7'h00, pass_rise} << `COCR_IRQ_PASS_RISE;
   wire [7:0] fall_event = {7'h00, pass_fall} << `COCR_IRQ_PASS_FALL;
   assign irq_events = rise_event | fall_event;
   // Clear register is write-one-to-clear and stores nothing
   cocr_byte_t irq_clear;
   assign irq_clear = wr_icl ? WDATA : 8'h00;
   // Set wins over a clear in the same cycle
   cocr_byte_t next_status;
   assign next_status = (irq_status & ~irq_clear) | irq_events;

   // Edge memory resets to the idle level of pass, so no false edge follows reset
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pass_prev <= 1'b0;
      end else begin
         pass_prev <= pass_level;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         irq_status <= `COCR_RST_IRQ;
      end else begin
         irq_status <= next_status;
      end
   end

   assign IRQ = |(irq_status & irq_enable);

   // ----------------------------------------------------------------
   // RAW placement
   // ----------------------------------------------------------------
   cocr_raw_place #(
      .RAW_W(RAW_W),
      .BUS_W(BUS_W)
   ) u_raw_place (
      .CLOCK(CLOCK),
      .RST(RST),
      .TO_MSB(raw_pixel_placement[`COCR_BIT_RAW_MSB]),
      .RAW_IN(RAW_IN),
      .BUS_OUT(COLOUR_BUS)
   );
endmodule : cocr_regs

// File: cocr_regs_properties.sv
// Port-level checker for the camera output config register bank
`timescale 1ns/1ps
module cocr_regs_chk #(
   parameter int RAW_W = 12,
   parameter int BUS_W = 24
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic PASS_IN,
   input wire logic PORT_A_AUTO_EN,
   input wire logic [RAW_W-1:0] RAW_IN,
   input wire logic [BUS_W-1:0] COLOUR_BUS,
   input wire logic [5:0] PORT_A_LANES,
   input wire logic [1:0] STREAM_CHANNEL_TAG,
   input wire logic GENERAL_PIN_0_OUT,
   input wire logic GENERAL_PIN_0_OE,
   input wire logic GENERAL_PIN_3_OE
);
   // ------------------------------
   // Shadows, same edge as the bank
   // ------------------------------
   logic raw;
   logic [7:0] pa;
   logic [1:0] vc;
   logic [7:1] pr;
   wire [5:0] lanes_exp = pa[7] ? pa[5:0] : {6{PORT_A_AUTO_EN}};
   wire [BUS_W-1:0] bus_exp = raw ? {RAW_IN, {(BUS_W-RAW_W){1'b0}}} : BUS_W'(RAW_IN);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         raw <= 1'b0;
         pa <= 8'h3F;
         vc <= 2'h0;
         pr <= 7'h01;
      end else if (WR) begin
         case (ADDR)
            8'h09: raw <= WDATA[4];
            8'h13: pa <= WDATA;
            8'h16: pr <= WDATA[7:1];
            8'h2E: vc <= WDATA[7:6];
            default: ;
         endcase
      end
   end
   // Pass must sit still past the synchroniser before pins may be judged
   sequence s_hi; PASS_IN [*8]; endsequence
   sequence s_lo; !PASS_IN [*8]; endsequence
   sequence s_rd; RD && ADDR == 8'h16; endsequence
   property p_raw; 1 |=> COLOUR_BUS == $past(bus_exp); endproperty
   a_raw: assert property (p_raw) else $error("bus placement");
   property p_lane; 1 |=> PORT_A_LANES == $past(lanes_exp); endproperty
   a_lane: assert property (p_lane) else $error("port a lanes");
   property p_vc; 1 |=> STREAM_CHANNEL_TAG == $past(vc); endproperty
   a_vc: assert property (p_vc) else $error("channel tag");
   property p_oe0; 1 |=> GENERAL_PIN_0_OE == $past(pr[1]); endproperty
   a_oe0: assert property (p_oe0) else $error("pin 0 enable");
   property p_oe3; 1 |=> GENERAL_PIN_3_OE == $past(pr[2]); endproperty
   a_oe3: assert property (p_oe3) else $error("pin 3 enable");
   property p_on; s_hi |-> GENERAL_PIN_0_OUT == $past(pr[1]); endproperty
   a_on: assert property (p_on) else $error("pin 0 pass high");
   property p_off; s_lo |-> !GENERAL_PIN_0_OUT; endproperty
   a_off: assert property (p_off) else $error("pin 0 pass low");
   property p_rdr; s_rd |=> RDATA[7:1] == $past(pr); endproperty
   a_rdr: assert property (p_rdr) else $error("routing readback");
endmodule : cocr_regs_chk
bind cocr_regs cocr_regs_chk #(.RAW_W(RAW_W), .BUS_W(BUS_W)) u_chk (.*);

// File: cocr_regs_test.sv
// Self-checking bench for the camera output config register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
$display("ERROR %s exp %h got %h", n, e, g); end end
module cocr_regs_test;
   import cocr_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, pass = 0, aa = 1, ab = 0;
   logic [7:0] addr = 0, wdata = 0, rdata, e, d;
   logic [11:0] raw = 0, raw_q = 0;
   logic [23:0] bus;
   logic [5:0] la, lb;
   logic [1:0] tag;
   logic p0o, p0e, p3o, p3e, irq;
   logic [7:0] exp_q[$];
   logic [7:0] ra[6] = '{8'h09, 8'h13, 8'h14, 8'h16, 8'h2E, 8'h20};
   logic [7:0] rv[6] = '{8'h00, 8'h3F, 8'h00, 8'h02, 8'h00, 8'h00};
   logic [7:0] rm[6] = '{8'h10, 8'hBF, 8'hBF, 8'h07, 8'hC0, 8'hFF};
   int seed = 32'h5A9857A8, n_mismatch = 0, num_checks = 0;
   cocr_regs DUT (.CLOCK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .PASS_IN(pass), .PORT_A_AUTO_EN(aa), .PORT_B_AUTO_EN(ab),
      .RAW_IN(raw), .COLOUR_BUS(bus), .PORT_A_LANES(la), .PORT_B_LANES(lb),
      .STREAM_CHANNEL_TAG(tag), .GENERAL_PIN_0_OUT(p0o), .GENERAL_PIN_0_OE(p0e),
      .GENERAL_PIN_3_OUT(p3o), .GENERAL_PIN_3_OE(p3e), .IRQ(irq));
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      raw <= 12'($random(seed));
      raw_q <= raw;
      rd_d <= rd;
   end
   // Read data stands only in the cycle after the strobe
   always @(negedge clk) begin
      if (rd_d) begin
         e = exp_q.pop_front();
         `CHK("rdata", e, rdata)
      end
   end
   task automatic wr8(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      repeat (2) @(negedge clk);
   endtask : wr8
   task automatic rd8(input logic [7:0] a, input logic [7:0] v);
      exp_q.push_back(v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask : rd8
   task automatic conclude();
      if (n_mismatch == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (4000) @(posedge clk);
      n_mismatch++;
      conclude();
   end
   // --------
   // Stimulus
   // --------
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      foreach (ra[i]) rd8(ra[i], rv[i]);
      `CHK("lanes", 12'hFC0, {la, lb})
      foreach (ra[i]) begin
         d = 8'($random(seed)) & rm[i];
         wr8(ra[i], d);
         rd8(ra[i], ra[i] == 8'h20 ? 8'h00 : ra[i] == 8'h16 ? {d[7:1], 1'b0} : d);
      end
      wr8(8'h13, 8'h80);
      `CHK("lanes_a", 6'h00, la)
      wr8(8'h13, 8'hBF);
      wr8(8'h14, 8'hBF);
      `CHK("lanes", 12'hFFF, {la, lb})
      @(posedge clk);
      ab <= 1'b1;
      wr8(8'h14, 8'h00);
      `CHK("lanes_b", 6'h3F, lb)
      for (int v = 0; v < 4; v++) begin
         wr8(8'h2E, {v[1:0], 6'h00});
         `CHK("tag", v[1:0], tag)
      end
      wr8(8'h09, 8'h10);
      `CHK("bus", {raw_q, 12'h000}, bus)
      wr8(8'h09, 8'h00);
      `CHK("bus", {12'h000, raw_q}, bus)
      wr8(8'h16, 8'h03);
      wr8(8'h41, 8'h01);
      @(posedge clk);
      pass <= 1'b1;
      repeat (9) @(negedge clk);
      `CHK("pins", 5'h19, {p0e, p0o, p3e, p3o, irq})
      rd8(8'h16, 8'h03);
      rd8(8'h40, 8'h01);
      wr8(8'h16, 8'h04);
      wr8(8'h42, 8'h01);
      `CHK("pins", 5'h06, {p0e, p0o, p3e, p3o, irq})
      @(posedge clk);
      pass <= 1'b0;
      repeat (9) @(negedge clk);
      `CHK("pins", 5'h04, {p0e, p0o, p3e, p3o, irq})
      rd8(8'h40, 8'h02);
      rd8(8'h16, 8'h04);
      repeat (3) @(posedge clk);
      conclude();
   end
endmodule : cocr_regs_test
